// *** common/ihp_pkg.sv ***
// constants for the host port and floppy dma handshake
package ihp_pkg;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned ADDR_W      = 10;
   localparam int unsigned SYNC_STAGES = 3;
   // terminal count polarity modes
   typedef enum logic [1:0] {
      IHP_MODE_AT   = 2'b00,
      IHP_MODE_PS30 = 2'b01,
      IHP_MODE_PS   = 2'b10
   } ihp_mode_t;
   // handshake states
   typedef enum logic [1:0] {
      IHP_ST_IDLE = 2'b00,
      IHP_ST_REQ  = 2'b01,
      IHP_ST_XFER = 2'b10
   } ihp_state_t;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [9:0] ADDR_RST = 10'h000;
endpackage

// *** verilog/ihp_host_port.sv ***
// isa host port slave with floppy dma handshake
// Summary of operation
// - data lines float except while driving read data.
// - address enable high marks dma cycles; port decodes are blocked then.
// - address latched on leading edge of read or write strobe.
// - dma request raised to ask for one byte transfer.
// - last byte: request drops on acknowledge fall, or read fall if already low.
// - dma data path enabled only while acknowledge is low.
// - accepted terminal count ends the current transfer.
// - terminal count ignored unless floppy or parallel acknowledge low.
// - terminal count active high in at and model 30 modes, low otherwise.
// - reset clears functional state; configuration inputs untouched.
`timescale 1ns/1ps
module ihp_host_port #(
   parameter logic [9:0] BASE_ADDR = 10'h3f0,
   parameter logic [9:0] ADDR_MASK = 10'h3f8
) (
   input  wire logic                      clk,
   input  wire logic                      reset,
   input  wire logic [ihp_pkg::DATA_W-1:0] data_in,
   output logic      [ihp_pkg::DATA_W-1:0] data_out,
   output logic      [ihp_pkg::DATA_W-1:0] data_oe_n,
   input  wire logic [ihp_pkg::ADDR_W-1:0] io_address,
   input  wire logic                      io_read_strobe_n,
   input  wire logic                      io_write_strobe_n,
   input  wire logic                      address_enable,
   output logic                           floppy_dma_request,
   input  wire logic                      dma_acknowledge_n,
   input  wire logic                      parallel_dma_acknowledge_n,
   input  wire logic                      terminal_count,
   input  wire ihp_pkg::ihp_mode_t        tc_mode,
   input  wire logic                      core_dma_want,
   input  wire logic                      core_last_byte,
   input  wire logic [ihp_pkg::DATA_W-1:0] core_read_data,
   output logic                           port_read,
   output logic                           port_write,
   output logic                           dma_read,
   output logic                           dma_write,
   output logic [ihp_pkg::ADDR_W-1:0]     port_offset,
   output logic [ihp_pkg::DATA_W-1:0]     write_data,
   output logic                           dma_done
);
   initial begin
      if (ihp_pkg::SYNC_STAGES != 3) $error("sync depth must be three");
   end

   // pin synchronisers: stage0 feeds stage1 only; stages 1 and 2 must agree
   localparam int unsigned NS = 5;
   logic [NS-1:0] pin_raw;
   logic [NS-1:0] s0_q, s1_q, s2_q, s0_d, s1_d, s2_d;
   logic [NS-1:0] flt_q, flt_d;
   assign pin_raw = {terminal_count, parallel_dma_acknowledge_n, dma_acknowledge_n,
                     io_write_strobe_n, io_read_strobe_n};

   always_comb begin
      s0_d  = pin_raw;
      s1_d  = s0_q;
      s2_d  = s1_q;
      flt_d = flt_q;
      for (int i = 0; i < NS; i++) begin
         if (s1_q[i] == s2_q[i]) flt_d[i] = s2_q[i];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s0_q  <= 5'h0f;
         s1_q  <= 5'h0f;
         s2_q  <= 5'h0f;
         flt_q <= 5'h0f;
      end else begin
         s0_q  <= s0_d;
         s1_q  <= s1_d;
         s2_q  <= s2_d;
         flt_q <= flt_d;
      end
   end

   logic rd_n, wr_n, ack_n, pack_n, tc_raw;
   assign rd_n   = flt_q[0];
   assign wr_n   = flt_q[1];
   assign ack_n  = flt_q[2];
   assign pack_n = flt_q[3];
   assign tc_raw = flt_q[4];

   function automatic logic tc_asserted(input logic lvl, input ihp_pkg::ihp_mode_t m);
      tc_asserted = (m == ihp_pkg::IHP_MODE_PS) ? !lvl : lvl;
   endfunction

   // state
   ihp_pkg::ihp_state_t st_q, st_d;
   logic rd_n_q, wr_n_q, ack_n_q;
   logic [ihp_pkg::ADDR_W-1:0] addr_q, addr_d;
   logic [ihp_pkg::DATA_W-1:0] dout_q, dout_d, wdat_q, wdat_d;
   logic drive_q, drive_d, req_q, req_d;
   logic [ihp_pkg::DATA_W-1:0] oe_q, oe_d;
   logic prd_q, prd_d, pwr_q, pwr_d, drd_q, drd_d, dwr_q, dwr_d, done_q, done_d;
   logic rd_fall, wr_fall, ack_fall, tc_ok, sel;

   always_comb begin
      rd_fall  = rd_n_q && !rd_n;
      wr_fall  = wr_n_q && !wr_n;
      ack_fall = ack_n_q && !ack_n;
      // qualify with either acknowledge low
      tc_ok = tc_asserted(tc_raw, tc_mode) && (!ack_n || !pack_n);
      addr_d = addr_q;
      if (rd_fall || wr_fall) addr_d = io_address;
      // decode blocked during dma cycles
      sel = !address_enable && ((addr_d & ADDR_MASK) == (BASE_ADDR & ADDR_MASK));
      st_d   = st_q;
      req_d  = req_q;
      done_d = 1'b0;
      prd_d  = 1'b0;
      pwr_d  = 1'b0;
      drd_d  = 1'b0;
      dwr_d  = 1'b0;
      wdat_d = wdat_q;
      dout_d = dout_q;
      drive_d = drive_q;
      case (st_q)
         ihp_pkg::IHP_ST_IDLE: begin
            if (core_dma_want) begin
               req_d = 1'b1;
               st_d  = ihp_pkg::IHP_ST_REQ;
            end
         end
         ihp_pkg::IHP_ST_REQ: begin
            // last byte: drop on ack fall, or on read fall in demand mode
            if (core_last_byte && (ack_fall || (!ack_n && rd_fall))) req_d = 1'b0;
            if (!ack_n) st_d = ihp_pkg::IHP_ST_XFER;
         end
         ihp_pkg::IHP_ST_XFER: begin
            if (core_last_byte && rd_fall && !ack_n) req_d = 1'b0;
            if (ack_n) begin
               st_d  = core_dma_want && req_q ? ihp_pkg::IHP_ST_REQ : ihp_pkg::IHP_ST_IDLE;
               req_d = req_q && core_dma_want;
            end
         end
         default: begin
            st_d  = ihp_pkg::IHP_ST_IDLE;
            req_d = 1'b0;
         end
      endcase
      if (tc_ok && st_q != ihp_pkg::IHP_ST_IDLE) begin
         done_d = 1'b1;
         req_d  = 1'b0;
         st_d   = ihp_pkg::IHP_ST_IDLE;
      end
      // dma path only with acknowledge low
      if (!ack_n) begin
         drd_d = rd_fall;
         dwr_d = wr_fall;
         if (wr_fall) wdat_d = data_in;
      end else if (sel) begin
         prd_d = rd_fall;
         pwr_d = wr_fall;
         if (wr_fall) wdat_d = data_in;
      end
      // drive only for a decoded read or an acknowledged dma read
      drive_d = !rd_n && (!ack_n || sel);
      if (drive_d) dout_d = core_read_data;
      // enable kept in its own flop so the pin comes straight from a register
      oe_d = drive_d ? 8'h00 : 8'hff;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_q    <= ihp_pkg::IHP_ST_IDLE;
         rd_n_q  <= 1'b1;
         wr_n_q  <= 1'b1;
         ack_n_q <= 1'b1;
         addr_q  <= ihp_pkg::ADDR_RST;
         dout_q  <= ihp_pkg::DATA_RST;
         wdat_q  <= ihp_pkg::DATA_RST;
         drive_q <= 1'b0;
         oe_q    <= 8'hff;
         req_q   <= 1'b0;
         prd_q   <= 1'b0;
         pwr_q   <= 1'b0;
         drd_q   <= 1'b0;
         dwr_q   <= 1'b0;
         done_q  <= 1'b0;
      end else begin
         st_q    <= st_d;
         rd_n_q  <= rd_n;
         wr_n_q  <= wr_n;
         ack_n_q <= ack_n;
         addr_q  <= addr_d;
         dout_q  <= dout_d;
         wdat_q  <= wdat_d;
         drive_q <= drive_d;
         oe_q    <= oe_d;
         req_q   <= req_d;
         prd_q   <= prd_d;
         pwr_q   <= pwr_d;
         drd_q   <= drd_d;
         dwr_q   <= dwr_d;
         done_q  <= done_d;
      end
   end

   // enable is active low; all bits float together
   always_comb begin
      data_out  = dout_q;
      data_oe_n = oe_q;
   end
   assign floppy_dma_request = req_q;
   assign port_read   = prd_q;
   assign port_write  = pwr_q;
   assign dma_read    = drd_q;
   assign dma_write   = dwr_q;
   assign port_offset = addr_q;
   assign write_data  = wdat_q;
   assign dma_done    = done_q;
endmodule

// *** dv/ihp_host_port_chk.sv ***
// assertion checker for the host port
`timescale 1ns/1ps
module ihp_chk (
   input wire logic               clk,
   input wire logic               reset,
   input wire logic [7:0]         data_oe_n,
   input wire logic               io_read_strobe_n,
   input wire logic               address_enable,
   input wire logic               floppy_dma_request,
   input wire logic               dma_acknowledge_n,
   input wire logic               parallel_dma_acknowledge_n,
   input wire logic               terminal_count,
   input wire ihp_pkg::ihp_mode_t tc_mode,
   input wire logic               core_dma_want,
   input wire logic               dma_read,
   input wire logic               dma_done
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   property p_oe; data_oe_n == 8'hff || data_oe_n == 8'h00; endproperty
   a_oe: assert property (p_oe) else $error("enable bits split");
   property p_drv; $fell(data_oe_n[0]) |-> !$past(io_read_strobe_n, 3); endproperty
   a_drv: assert property (p_drv) else $error("drive without read");
   property p_aen; $fell(data_oe_n[0]) && address_enable |-> !dma_acknowledge_n; endproperty
   a_aen: assert property (p_aen) else $error("drive in dma cycle");
   property p_req; $rose(core_dma_want) |=> floppy_dma_request; endproperty
   a_req: assert property (p_req) else $error("request late");
   property p_drop; $fell(floppy_dma_request) |-> !$past(dma_acknowledge_n, 3); endproperty
   a_drop: assert property (p_drop) else $error("request dropped early");
   property p_path; dma_read |-> !$past(dma_acknowledge_n, 3); endproperty
   a_path: assert property (p_path) else $error("dma path without ack");
   property p_tc; dma_done |-> $past(terminal_count, 3) == (tc_mode != ihp_pkg::IHP_MODE_PS)
      && !$past(dma_acknowledge_n && parallel_dma_acknowledge_n, 3); endproperty
   a_tc: assert property (p_tc) else $error("bad count accept");
   property p_rst; $fell(reset) |-> data_oe_n == 8'hff && !floppy_dma_request; endproperty
   a_rst: assert property (p_rst) else $error("reset values");
endmodule
bind ihp_host_port ihp_chk ihp_chk_inst (.*);

// *** dv/ihp_host_model.sv ***
// host processor and dma controller model
`timescale 1ns/1ps
module ihp_host_model (
   input  wire logic [7:0] data_out,
   input  wire logic [7:0] data_oe_n,
   input  wire logic       clk,
   output logic [7:0]      data_in,
   output logic [9:0]      io_address = 10'h000,
   output logic            io_read_strobe_n = 1,
   output logic            io_write_strobe_n = 1,
   output logic            address_enable = 0,
   output logic            dma_acknowledge_n = 1,
   output logic            parallel_dma_acknowledge_n = 1,
   output logic            terminal_count = 0
);
   logic [7:0] wd = 8'h00;
   logic [7:0] prev = 8'h00;
   logic       wr = 0;
   // no pull-up: a released bus toggles so stale data cannot pass
   assign data_in = !data_oe_n[0] ? data_out : wr ? wd : ~prev;
   always @(posedge clk) prev <= data_in;
   task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d,
                      input logic e, output logic [7:0] q);
      @(posedge clk) #1;
      io_address = a;
      address_enable = e;
      wd = d;
      wr = w;
      if (w) io_write_strobe_n = 0;
      else io_read_strobe_n = 0;
      repeat (8) @(posedge clk);
      q = data_in;
      #1;
      io_read_strobe_n = 1;
      io_write_strobe_n = 1;
      wr = 0;
      repeat (6) @(posedge clk);
   endtask
   task automatic sig(input logic k, input logic t);
      @(posedge clk) #1;
      dma_acknowledge_n = k;
      terminal_count = t;
   endtask
endmodule

// *** dv/tb.sv ***
// self-checking bench for the host port
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
   logic               clk = 0, reset = 1, core_dma_want = 0, core_last_byte = 0;
   logic [7:0]         core_read_data = 8'h5a, data_in, data_out, data_oe_n, write_data, q;
   logic [9:0]         io_address, port_offset;
   logic               io_read_strobe_n, io_write_strobe_n, address_enable;
   logic               floppy_dma_request, dma_acknowledge_n, parallel_dma_acknowledge_n;
   logic               terminal_count, port_read, port_write, dma_read, dma_write, dma_done;
   logic [4:0]         seen = 5'h00;
   ihp_pkg::ihp_mode_t tc_mode = ihp_pkg::IHP_MODE_AT;
   int                 n_errors = 0, samples_checked = 0, cyc = 0;
   ihp_host_port ihp_host_port_inst (.*);
   ihp_host_model ihp_host_model_inst (.*);
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) seen <= seen | {port_read, port_write, dma_read, dma_write, dma_done};
   always @(posedge clk) if (++cyc > 3000) begin n_errors++; end_sim(); end
   task tick(input int n); repeat (n) @(posedge clk); #1; endtask
   task end_sim;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task t_port; // decoded read, refused reads, decoded write
      seen = 0;
      ihp_host_model_inst.acc(0, 10'h3f5, 8'h00, 0, q);
      `CHK(q, 8'h5a)
      `CHK({seen, port_offset, data_oe_n}, {5'b10000, 10'h3f5, 8'hff})
      ihp_host_model_inst.acc(0, 10'h3e5, 8'h00, 0, q);
      ihp_host_model_inst.acc(0, 10'h3f5, 8'h00, 1, q);
      `CHK(seen, 5'b10000)
      ihp_host_model_inst.acc(1, 10'h3f2, 8'ha5, 0, q);
      `CHK({seen, write_data, port_offset}, {5'b11000, 8'ha5, 10'h3f2})
   endtask
   task t_dma(input ihp_pkg::ihp_mode_t md);
      logic act;
      act = (md != ihp_pkg::IHP_MODE_PS);
      // let the previous acknowledge release pass the filter first
      tick(6);
      tc_mode = md;
      seen = 0;
      ihp_host_model_inst.sig(1, act);
      core_dma_want = 1;
      tick(6);
      core_dma_want = 0;
      `CHK({floppy_dma_request, seen[0]}, 2'b10)
      ihp_host_model_inst.sig(0, !act);
      ihp_host_model_inst.acc(0, 10'h000, 8'h00, 1, q);
      `CHK({q, seen[2:0]}, {8'h5a, 3'b100})
      ihp_host_model_inst.acc(1, 10'h000, 8'h3c, 1, q);
      `CHK({write_data, seen[1]}, {8'h3c, 1'b1})
      ihp_host_model_inst.sig(0, act);
      tick(8);
      `CHK({seen[0], floppy_dma_request}, 2'b10)
      ihp_host_model_inst.sig(1, !act);
   endtask
   task t_last; // demand mode: ack already low, read fall drops it
      tick(6);
      core_dma_want = 1;
      tick(6);
      core_dma_want = 0;
      ihp_host_model_inst.sig(0, 0);
      tick(8);
      core_last_byte = 1;
      tick(2);
      `CHK(floppy_dma_request, 1'b1)
      ihp_host_model_inst.acc(0, 10'h000, 8'h00, 1, q);
      `CHK(floppy_dma_request, 1'b0)
      core_last_byte = 0;
      ihp_host_model_inst.sig(1, 0);
   endtask
   initial begin
      tick(10);
      reset = 0;
      tick(6);
      `CHK({data_oe_n, floppy_dma_request}, {8'hff, 1'b0})
      t_port();
      t_dma(ihp_pkg::IHP_MODE_AT);
      t_dma(ihp_pkg::IHP_MODE_PS30);
      t_dma(ihp_pkg::IHP_MODE_PS);
      tc_mode = ihp_pkg::IHP_MODE_AT;
      t_last();
      end_sim();
   end
endmodule
